// ### bench/taipg_host_model.sv
/*
  Host side model: writes data words and command codes to the generator.
  Assumes one clock; the bench calls its tasks to load and start moves.
*/
`timescale 1ns/1ps
module taipg_host_model (
  input  wire logic        clk_sys,
  output logic             cmdWrite,
  output logic [15:0]      commandRegister,
  output logic [15:0]      dataLowWordRegister,
  output logic [15:0]      dataHighWordRegister
);
  // Bus idle at time zero
  initial begin
    cmdWrite = 1'b0;
    commandRegister = 16'h0000;
    {dataHighWordRegister, dataLowWordRegister} = 32'h0000_0000;
  end

  // One command cycle; data scrambled once released so stale words cannot pass
  task automatic cmd(input logic [15:0] code, input logic [31:0] d);
    @(posedge clk_sys) #2;
    {dataHighWordRegister, dataLowWordRegister} = d;
    commandRegister = code;
    cmdWrite = 1'b1;
    @(posedge clk_sys) #2;
    cmdWrite = 1'b0;
    {dataHighWordRegister, dataLowWordRegister} = ~d;
  endtask

  // Finish and centre first, start command last
  task automatic move(input logic [15:0] start, input int xf, input int yf,
                      input int xc, input int yc);
    cmd(16'h0106, 32'(xf));
    cmd(16'h0206, 32'(yf));
    cmd(16'h0108, 32'(xc));
    cmd(16'h0208, 32'(yc));
    cmd(start, 32'h0000_0000);
  endtask
endmodule // taipg_host_model

// ### bench/testbench.sv
/*
  Self-checking bench of the interpolation pulse generator.
  Assumes the host model drives commands; limits and in-position pins here.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  typedef struct {int x; int y; int mode; logic [15:0] st; logic [3:0] ex; logic [3:0] ey;
    int xc; int yc;} taipg_note_s;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] period = 32'd10;
  logic contMode = 1'b0;
  logic inPosEnable = 1'b0;
  logic xInp_n = 1'b1;
  logic yInp_n = 1'b1;
  taipg_pkg::taipg_limit_s xLim = '0;
  taipg_pkg::taipg_limit_s yLim = '0;
  logic cmdWrite;
  logic [15:0] cmdCode, dLow, dHigh, st;
  logic [3:0] xErr, yErr;
  taipg_pkg::taipg_step_s stepOut;
  taipg_note_s q[$];
  taipg_note_s n;
  int n_mismatch = 0;
  int checked = 0;
  int xNet = 0, yNet = 0, cyc = 0, lastX = -1000;
  logic wasRun = 1'b0;
  longint dd, r2;

  always #12.5 clk_sys = ~clk_sys;

  taipg_host_model host (.clk_sys(clk_sys), .cmdWrite(cmdWrite), .commandRegister(cmdCode),
    .dataLowWordRegister(dLow), .dataHighWordRegister(dHigh));
  taipg_interp dut (.clk_sys(clk_sys), .rst(rst), .cmdWrite(cmdWrite), .commandRegister(cmdCode),
    .dataLowWordRegister(dLow), .dataHighWordRegister(dHigh), .xStepPeriod(period),
    .contMode(contMode), .inPosEnable(inPosEnable), .xLimitPin(xLim), .yLimitPin(yLim),
    .xInPositionInput_n(xInp_n), .yInPositionInput_n(yInp_n), .mainStatusRegister(st),
    .xAxisErrorRegister(xErr), .yAxisErrorRegister(yErr), .stepOut(stepOut));

  // Watcher: nets pulses, checks spacing, compares each finished move with its note
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    wasRun <= st[8];
    if (stepOut.xPulse) begin
      xNet <= xNet + (stepOut.xDir ? -1 : 1);
      lastX <= cyc;
      `CHK(cyc - lastX >= (contMode ? 20 : 10), 1'b1)
    end
    if (stepOut.yPulse) yNet <= yNet + (stepOut.yDir ? -1 : 1);
    // Circle moves: position stays within one step of the ideal radius
    if (st[8] && q.size() > 0) begin
      r2 = q[0].xc * q[0].xc + q[0].yc * q[0].yc;
      dd = (xNet - q[0].xc) * (xNet - q[0].xc) + (yNet - q[0].yc) * (yNet - q[0].yc);
      if (r2 > 0) `CHK((dd + r2 - 1) * (dd + r2 - 1) <= 4 * dd * r2, 1'b1)
    end
    if (wasRun && st[8] === 1'b0 && q.size() > 0) begin
      n = q.pop_front();
      `CHK(st, n.st)
      `CHK({xErr, yErr}, {n.ex, n.ey})
      if (n.mode == 1) `CHK(xNet, n.x)
      if (n.mode > 0) `CHK(yNet, n.y)
      xNet <= 0;
      yNet <= 0;
      lastX <= -1000;
    end
  end

  task automatic summarize();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Queue a note, start the move, check running flags, wait bounded for the result
  task automatic run(input logic [15:0] c, input int xf, yf, xc, yc, m,
                     input logic [15:0] s, input logic [3:0] ex, ey, input int lim);
    int i;
    q.push_back('{xf, yf, m, s, ex, ey, xc, yc});
    host.move(c, xf, yf, xc, yc);
    repeat (3) @(posedge clk_sys);
    #2 `CHK(st & 16'h0103, 16'h0103)
    if (lim > 0) begin
      repeat (lim) @(posedge clk_sys);
      #2 xLim = ex;
      yLim = ey;
    end
    for (i = 0; i < 40000 && q.size() > 0; i++) @(posedge clk_sys);
    if (q.size() > 0) begin
      n_mismatch++;
      summarize();
    end
    #2 xLim = '0;
    yLim = '0;
  endtask

  initial begin
    int x, y, k;
    void'($urandom(32'h49eab7c6));
    repeat (16) @(posedge clk_sys);
    #2 rst = 1'b0;
    period = 32'($urandom_range(9, 1)); // Faster than the top rate, so the clamp must act
    run(16'h0030, 3, -2, 0, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
    for (k = 0; k < 3; k++) begin
      x = $urandom_range(40) - 20;
      y = $urandom_range(40) - 20;
      if (x == 0) x = 7;
      run(16'h0030, x, y, 0, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
    end
    contMode = 1'b1;
    run(16'h0030, -6, 9, 0, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
    contMode = 1'b0;
    run(16'h0032, 0, 0, -11, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
    run(16'h0033, 0, 0, -11, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
    run(16'h0033, -702, 299, -200, 500, 2, 16'h0000, 4'h0, 4'h0, 0);
    run(16'h0030, 1000, 10, 0, 0, 0, 16'h0010, 4'h8, 4'h0, 60);
    run(16'h0032, 0, 0, -11, 0, 0, 16'h0020, 4'h0, 4'h1, 60);
    // In-position wait: flag must outlast the last pulse until both inputs go active
    inPosEnable = 1'b1;
    fork
      run(16'h0030, 5, 5, 0, 0, 1, 16'h0000, 4'h0, 4'h0, 0);
      begin
        repeat (300) @(posedge clk_sys);
        #2 `CHK(st[8], 1'b1)
        xInp_n = 1'b0;
        yInp_n = 1'b0;
      end
    join
    summarize();
  end
endmodule // testbench

// ### verilog/taipg_interp.sv
/*
  Two-axis interpolation pulse generator: linear and circular moves
  with one common step clock, limit stop and in-position wait.
  Assumes host bus decode outside; command, data and limits arrive as
  ports. Limit and in-position pins are asynchronous.
*/
// Overview of operation
// - Step period is taken from the X axis speed setting.
// - Interpolation flag bit 8 is 1 while running, 0 when done.
// - X and Y driving flags bits 0 and 1 are 1 while running.
// - Step rate at most 4 Mpps, continuous mode at most 2 Mpps.
// - In linear moves, a hardware or software limit in either axis's direction of travel stops the move.
// - Error stop sets X bit 4 or Y bit 5 and the axis error cause.
// - In circular moves, a limit of either direction stops the move.
// - With in-position enabled, a finished move clears the flag only after both inputs active.
// - Interpolation finish values are signed and carry the direction.
// - Linear path stays within half an LSB of the ideal line.
// - Long axis steps every tick; short axis by distance ratio.
// - Linear finish coordinates are 24-bit signed values.
// - Circle center and finish are offsets from the start point.
// - Finish (0,0) gives a whole circle.
// - X long in octants 0,3,4,7; Y long in 1,2,5,6.
// - Short axis steps every tick; long axis follows circle error.
// - Circle ends when short axis reaches finish in finish octant.
// - Circle path stays within one LSB of the ideal circle.
// - Circle finish spans plus and minus 8,388,608; center spans plus and minus 16,777,216.
`timescale 1ns/1ps
`include "taipg_regs.svh"
module taipg_interp (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          cmdWrite,
  input  wire logic [15:0]                   commandRegister,
  input  wire logic [15:0]                   dataLowWordRegister,
  input  wire logic [15:0]                   dataHighWordRegister,
  input  wire logic [`TAIPG_RATE_W-1:0]      xStepPeriod,
  input  wire logic                          contMode,
  input  wire logic                          inPosEnable,
  input  wire taipg_pkg::taipg_limit_s       xLimitPin,
  input  wire taipg_pkg::taipg_limit_s       yLimitPin,
  input  wire logic                          xInPositionInput_n,
  input  wire logic                          yInPositionInput_n,
  output logic [`TAIPG_ST_W-1:0]             mainStatusRegister,
  output logic [3:0]                         xAxisErrorRegister,
  output logic [3:0]                         yAxisErrorRegister,
  output taipg_pkg::taipg_step_s             stepOut
);
  typedef enum logic [1:0] {IDLE, RUN, INPOS} taipg_state_e;
  localparam int W = `TAIPG_COORD_W + 2;

  taipg_state_e            state_r;
  taipg_pkg::taipg_mode_e  mode_r;
  taipg_pkg::taipg_limit_s xLim1_r, xLim2_r, yLim1_r, yLim2_r;
  logic [1:0]              inp1_r, inp2_r;
  logic signed [W-1:0]     xFin_r, yFin_r, xCen_r, yCen_r;
  logic signed [W-1:0]     xPos_r, yPos_r;
  logic signed [`TAIPG_ACC_W-1:0] err_r;
  logic [W-1:0]            stepsLeft_r;
  logic                    tick;
  logic                    xErr, yErr;
  logic [31:0]             dataWord;

  // -------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------
  function automatic logic signed [W-1:0] absv(input logic signed [W-1:0] v);
    absv = v[W-1] ? -v : v;
  endfunction

  // Octant of a point measured from the center
  function automatic logic [2:0] octant(input logic signed [W-1:0] dx,
                                        input logic signed [W-1:0] dy);
    logic xl;
    xl = absv(dx) >= absv(dy);
    if (!dy[W-1] && !dx[W-1])     octant = xl ? 3'h0 : 3'h1;
    else if (!dy[W-1])            octant = xl ? 3'h3 : 3'h2;
    else if (dx[W-1])             octant = xl ? 3'h4 : 3'h5;
    else                          octant = xl ? 3'h7 : 3'h6;
  endfunction

  // Long axis is X in octants 0,3,4,7
  function automatic logic xIsLong(input logic [2:0] o);
    xIsLong = (o == 3'h0) || (o == 3'h3) || (o == 3'h4) || (o == 3'h7);
  endfunction

  // Limit active check; circle stops on either direction
  function automatic logic limHit(input taipg_pkg::taipg_limit_s l,
                                  input logic dirMinus, input logic anyDir);
    if (anyDir)
      limHit = l.hwPlus | l.hwMinus | l.swPlus | l.swMinus;
    else
      limHit = dirMinus ? (l.hwMinus | l.swMinus) : (l.hwPlus | l.swPlus);
  endfunction

  assign dataWord = {dataHighWordRegister, dataLowWordRegister};

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  // Two stages for every asynchronous pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xLim1_r <= '0;
      xLim2_r <= '0;
      yLim1_r <= '0;
      yLim2_r <= '0;
      inp1_r  <= 2'b00;
      inp2_r  <= 2'b00;
    end else begin
      xLim1_r <= xLimitPin;
      xLim2_r <= xLim1_r;
      yLim1_r <= yLimitPin;
      yLim2_r <= yLim1_r;
      inp1_r  <= {~yInPositionInput_n, ~xInPositionInput_n};
      inp2_r  <= inp1_r;
    end
  end

  // -------------------------------------------------------------
  // Parameter capture
  // -------------------------------------------------------------
  // Finish and center taken from the data words; ignored while running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xFin_r <= '0;
      yFin_r <= '0;
      xCen_r <= '0;
      yCen_r <= '0;
    end else if (cmdWrite && state_r == IDLE) begin
      if (commandRegister == `TAIPG_CMD_XFIN)
        xFin_r <= W'($signed(dataWord[`TAIPG_COORD_W-1:0]));
      else if (commandRegister == `TAIPG_CMD_YFIN)
        yFin_r <= W'($signed(dataWord[`TAIPG_COORD_W-1:0]));
      else if (commandRegister == `TAIPG_CMD_XCEN)
        xCen_r <= W'($signed(dataWord[`TAIPG_COORD_W:0]));
      else if (commandRegister == `TAIPG_CMD_YCEN)
        yCen_r <= W'($signed(dataWord[`TAIPG_COORD_W:0]));
    end
  end

  // -------------------------------------------------------------
  // Common step clock
  // -------------------------------------------------------------
  // X axis speed drives every interpolation step
  taipg_step_timer u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (state_r == RUN),
    .period   (xStepPeriod),
    .contMode (contMode),
    .tick     (tick)
  );

  // -------------------------------------------------------------
  // Motion geometry
  // -------------------------------------------------------------
  // Positions relative to the center; start point is the origin
  logic signed [W-1:0] relX, relY, finRX, finRY, dLong, dShort;
  logic [2:0]          oct, finOct;
  logic                xL, cw, sxNeg, syNeg, doneCircle;
  always_comb begin
    relX   = xPos_r - xCen_r;
    relY   = yPos_r - yCen_r;
    finRX  = xFin_r - xCen_r;
    finRY  = yFin_r - yCen_r;
    oct    = octant(relX, relY);
    finOct = octant(finRX, finRY);
    cw     = (mode_r == taipg_pkg::TAIPG_CW);
    xL     = xIsLong(oct);
    // Tangent direction: CCW goes (-y, x), CW goes (y, -x)
    // An axis sitting on the center line keeps its plus direction,
    // so a step off a quadrant edge never starts out backwards
    sxNeg  = cw ? relY[W-1] : ~relY[W-1] & (relY != '0);
    syNeg  = cw ? ~relX[W-1] & (relX != '0) : relX[W-1];
    // Short axis reaches the finish coordinate inside the finish octant
    doneCircle = (oct == finOct) && (xL ? (yPos_r == yFin_r) : (xPos_r == xFin_r));
    dLong  = absv(xFin_r) >= absv(yFin_r) ? absv(xFin_r) : absv(yFin_r);
    dShort = absv(xFin_r) >= absv(yFin_r) ? absv(yFin_r) : absv(xFin_r);
  end

  assign xErr = limHit(xLim2_r, mode_r == taipg_pkg::TAIPG_LINEAR ? xFin_r[W-1] : 1'b0,
                       mode_r != taipg_pkg::TAIPG_LINEAR);
  assign yErr = limHit(yLim2_r, mode_r == taipg_pkg::TAIPG_LINEAR ? yFin_r[W-1] : 1'b0,
                       mode_r != taipg_pkg::TAIPG_LINEAR);

  // -------------------------------------------------------------
  // Sequencer and stepping
  // -------------------------------------------------------------
  // Circle candidate errors for long-axis decision
  logic signed [`TAIPG_ACC_W-1:0] nxS, nxB;
  logic signed [W-1:0]            sNew, sOld, lNew, lOld;
  logic                           lgNeg, shNeg;
  always_comb begin
    shNeg = xL ? syNeg : sxNeg;
    lgNeg = xL ? sxNeg : syNeg;
    sNew  = xL ? (shNeg ? relY - W'(1) : relY + W'(1))
               : (shNeg ? relX - W'(1) : relX + W'(1));
    sOld  = xL ? relY : relX;
    lOld  = xL ? relX : relY;
    lNew  = lgNeg ? lOld - W'(1) : lOld + W'(1);
    // Error of x^2+y^2-r^2 for keep and for step of the long axis
    // Operands widen before squaring, else large radii wrap the product
    nxS = err_r + `TAIPG_ACC_W'(sNew) * `TAIPG_ACC_W'(sNew)
          - `TAIPG_ACC_W'(sOld) * `TAIPG_ACC_W'(sOld);
    nxB = nxS + `TAIPG_ACC_W'(lNew) * `TAIPG_ACC_W'(lNew)
          - `TAIPG_ACC_W'(lOld) * `TAIPG_ACC_W'(lOld);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r     <= IDLE;
      mode_r      <= taipg_pkg::TAIPG_LINEAR;
      xPos_r      <= '0;
      yPos_r      <= '0;
      err_r       <= '0;
      stepsLeft_r <= '0;
      stepOut     <= '0;
      xAxisErrorRegister <= 4'h0;
      yAxisErrorRegister <= 4'h0;
    end else begin
      stepOut <= '0;
      case (state_r)
        IDLE: begin
          if (cmdWrite && (commandRegister == `TAIPG_CMD_LIN ||
              commandRegister == `TAIPG_CMD_CW || commandRegister == `TAIPG_CMD_CCW)) begin
            state_r <= RUN;
            mode_r  <= commandRegister == `TAIPG_CMD_LIN ? taipg_pkg::TAIPG_LINEAR :
                       commandRegister == `TAIPG_CMD_CW  ? taipg_pkg::TAIPG_CW :
                                                           taipg_pkg::TAIPG_CCW;
            xPos_r  <= '0;
            yPos_r  <= '0;
            err_r   <= '0;
            stepsLeft_r <= '0;
            xAxisErrorRegister <= 4'h0;
            yAxisErrorRegister <= 4'h0;
          end
        end
        RUN: begin
          if (xErr || yErr) begin
            state_r <= IDLE;
            if (xErr) xAxisErrorRegister <= xLim2_r;
            if (yErr) yAxisErrorRegister <= yLim2_r;
          end else if (mode_r == taipg_pkg::TAIPG_LINEAR) begin
            if (stepsLeft_r == dLong) begin
              state_r <= inPosEnable ? INPOS : IDLE;
            end else if (tick) begin
              // Bresenham: long axis every tick, short by ratio
              stepsLeft_r <= stepsLeft_r + W'(1);
              if (err_r + `TAIPG_ACC_W'(2 * dShort) >= `TAIPG_ACC_W'(dLong)) begin
                err_r <= err_r + `TAIPG_ACC_W'(2 * dShort) - `TAIPG_ACC_W'(2 * dLong);
                if (absv(xFin_r) >= absv(yFin_r)) stepOut.yPulse <= 1'b1;
                else                               stepOut.xPulse <= 1'b1;
              end else begin
                err_r <= err_r + `TAIPG_ACC_W'(2 * dShort);
              end
              if (absv(xFin_r) >= absv(yFin_r)) stepOut.xPulse <= 1'b1;
              else                               stepOut.yPulse <= 1'b1;
              stepOut.xDir <= xFin_r[W-1];
              stepOut.yDir <= yFin_r[W-1];
              xPos_r <= xPos_r; // Position not tracked in linear mode
            end
          end else begin
            // Leave when at finish after one step; full circle needs two steps first
            if (doneCircle && (stepsLeft_r != '0) &&
                !((xFin_r == '0) && (yFin_r == '0) && (stepsLeft_r < W'(2)))) begin
              state_r <= inPosEnable ? INPOS : IDLE;
            end else if (tick) begin
              stepsLeft_r <= (stepsLeft_r == '1) ? stepsLeft_r : stepsLeft_r + W'(1);
              // Short axis always steps; long picks smaller error
              if ((nxB < 0 ? -nxB : nxB) < (nxS < 0 ? -nxS : nxS)) begin
                err_r <= nxB;
                if (xL) begin
                  xPos_r <= sxNeg ? xPos_r - W'(1) : xPos_r + W'(1);
                  stepOut.xPulse <= 1'b1;
                end else begin
                  yPos_r <= syNeg ? yPos_r - W'(1) : yPos_r + W'(1);
                  stepOut.yPulse <= 1'b1;
                end
              end else begin
                err_r <= nxS;
              end
              if (xL) begin
                yPos_r <= syNeg ? yPos_r - W'(1) : yPos_r + W'(1);
                stepOut.yPulse <= 1'b1;
              end else begin
                xPos_r <= sxNeg ? xPos_r - W'(1) : xPos_r + W'(1);
                stepOut.xPulse <= 1'b1;
              end
              stepOut.xDir <= sxNeg;
              stepOut.yDir <= syNeg;
            end
          end
        end
        INPOS: begin
          if (inp2_r == 2'b11) state_r <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Main status
  // -------------------------------------------------------------
  // Drive flags follow the sequencer, error flags hold until next start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mainStatusRegister <= '0;
    end else begin
      mainStatusRegister[`TAIPG_ST_IDRV] <= (state_r != IDLE);
      mainStatusRegister[`TAIPG_ST_XDRV] <= (state_r != IDLE);
      mainStatusRegister[`TAIPG_ST_YDRV] <= (state_r != IDLE);
      mainStatusRegister[`TAIPG_ST_XERR] <= (xAxisErrorRegister != 4'h0);
      mainStatusRegister[`TAIPG_ST_YERR] <= (yAxisErrorRegister != 4'h0);
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  drive_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == RUN) |=> mainStatusRegister[`TAIPG_ST_IDRV]) else $error("drive flag low");
  axis_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r != IDLE) |=> mainStatusRegister[`TAIPG_ST_XDRV]
    && mainStatusRegister[`TAIPG_ST_YDRV]) else $error("axis flags low");
  limit_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == RUN && xErr) |=> state_r == IDLE) else $error("no limit stop");
  error_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == RUN && yErr) |=> ##1 mainStatusRegister[`TAIPG_ST_YERR]) else $error("no y err");
  circle_any_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == RUN && mode_r != taipg_pkg::TAIPG_LINEAR && xLim2_r.hwMinus)
    |=> state_r == IDLE) else $error("circle ignored limit");
  inpos_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == INPOS && inp2_r != 2'b11) |=> state_r == INPOS) else $error("left early");
  common_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
    (stepOut.xPulse || stepOut.yPulse) |-> $past(tick)) else $error("pulse off tick");
  lin_long_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == RUN && mode_r == taipg_pkg::TAIPG_LINEAR && tick && !xErr && !yErr
     && stepsLeft_r != dLong && absv(xFin_r) >= absv(yFin_r)) |=> stepOut.xPulse)
    else $error("long axis missed");
endmodule // taipg_interp

// ### verilog/taipg_pkg.sv
/*
  Types of the two-axis interpolation pulse generator.
  Assumes taipg_regs.svh supplies the widths.
*/
`include "taipg_regs.svh"
package taipg_pkg;
  typedef enum logic [1:0] {
    TAIPG_LINEAR,
    TAIPG_CW,
    TAIPG_CCW
  } taipg_mode_e;

  // Per-axis limit inputs, all active high after synchronising
  typedef struct packed {
    logic hwPlus;
    logic hwMinus;
    logic swPlus;
    logic swMinus;
  } taipg_limit_s;

  // One interpolation step toward the pulse outputs
  typedef struct packed {
    logic xPulse;
    logic xDir;
    logic yPulse;
    logic yDir;
  } taipg_step_s;
endpackage

// ### verilog/taipg_regs.svh
/*
  Constants of the two-axis interpolation pulse generator: status bit
  positions, command codes, field widths and timing counts.
  Assumes a 40 MHz system clock and a host that decodes its own bus.
*/
`ifndef TAIPG_REGS_SVH
`define TAIPG_REGS_SVH

// ------------------------------------------------------------
// Main status bit positions
// ------------------------------------------------------------
`define TAIPG_ST_XDRV      0
`define TAIPG_ST_YDRV      1
`define TAIPG_ST_XERR      4
`define TAIPG_ST_YERR      5
`define TAIPG_ST_IDRV      8
`define TAIPG_ST_W         16

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define TAIPG_CMD_XFIN     16'h0106
`define TAIPG_CMD_YFIN     16'h0206
`define TAIPG_CMD_XCEN     16'h0108
`define TAIPG_CMD_YCEN     16'h0208
`define TAIPG_CMD_LIN      16'h0030
`define TAIPG_CMD_CW       16'h0032
`define TAIPG_CMD_CCW      16'h0033

// ------------------------------------------------------------
// Widths and timing
// ------------------------------------------------------------
`define TAIPG_COORD_W      24
`define TAIPG_ACC_W        50
`define TAIPG_CLK_HZ       40000000
`define TAIPG_MAX_PPS      4000000
`define TAIPG_CONT_PPS     2000000
// Least step spacing in clocks at the top rate, rounded up
`define TAIPG_MIN_STEP     ((`TAIPG_CLK_HZ + `TAIPG_MAX_PPS - 1) / `TAIPG_MAX_PPS)
`define TAIPG_MIN_STEPC    ((`TAIPG_CLK_HZ + `TAIPG_CONT_PPS - 1) / `TAIPG_CONT_PPS)
`define TAIPG_RATE_W       32
`define TAIPG_ONE24        24'h000001
`define TAIPG_ZERO24       24'h000000

`endif

// ### verilog/taipg_step_timer.sv
/*
  Common step timer: one tick every period of clocks, from which both
  axes take their pulses. Assumes the period was loaded while idle.
*/
`timescale 1ns/1ps
`include "taipg_regs.svh"
module taipg_step_timer (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     run,
  input  wire logic [`TAIPG_RATE_W-1:0] period,
  input  wire logic                     contMode,
  output logic                          tick
);
  logic [`TAIPG_RATE_W-1:0] cnt_r;
  logic [`TAIPG_RATE_W-1:0] lim;

  // -------------------------------------------------------------
  // Period clamp
  // -------------------------------------------------------------
  // Clamp to the fastest legal rate; continuous chains go half speed
  always_comb begin
    lim = period;
    if (contMode && period < `TAIPG_RATE_W'(`TAIPG_MIN_STEPC)) begin
      lim = `TAIPG_RATE_W'(`TAIPG_MIN_STEPC);
    end else if (period < `TAIPG_RATE_W'(`TAIPG_MIN_STEP)) begin
      lim = `TAIPG_RATE_W'(`TAIPG_MIN_STEP);
    end
  end

  // Free counter, restarted when idle
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= lim - `TAIPG_RATE_W'(1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + `TAIPG_RATE_W'(1);
      tick  <= 1'b0;
    end
  end

  tick_spacing_a: assert property (@(posedge clk_sys) disable iff (rst)
    tick |=> !tick) else $error("step ticks too close");
endmodule // taipg_step_timer
